// >>> rtl/sas_buf2.sv
module sas_buf2 #(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);

    logic [1:0] count_ff;
    logic [1:0] nxt_count;
    logic [W-1:0] slot0_ff;
    logic [W-1:0] slot1_ff;
    logic [W-1:0] nxt_slot0;
    logic [W-1:0] nxt_slot1;
    logic push;
    logic pop;
    logic valid_ff;
    logic nxt_valid;

    // honest full: only two words of room, then the source stalls
    assign inReady = (count_ff != 2'h2);
    // valid is its own flop so the block's output comes straight from one
    assign outValid = valid_ff;
    assign outData = slot0_ff;

    always_comb begin
        push = inValid && inReady;
        pop = outValid && outReady;
        nxt_count = count_ff;
        nxt_slot0 = slot0_ff;
        nxt_slot1 = slot1_ff;
        case ({push, pop})
            2'b10: begin
                nxt_count = count_ff + 2'h1;
                if (count_ff == 2'h0) begin
                    nxt_slot0 = inData;
                end else begin
                    nxt_slot1 = inData;
                end
            end
            2'b01: begin
                nxt_count = count_ff - 2'h1;
                nxt_slot0 = slot1_ff;
            end
            2'b11: begin
                if (count_ff == 2'h1) begin
                    nxt_slot0 = inData;
                end else begin
                    nxt_slot0 = slot1_ff;
                    nxt_slot1 = inData;
                end
            end
            default: begin
                nxt_count = count_ff;
            end
        endcase
        nxt_valid = (nxt_count != 2'h0);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_ff <= 2'h0;
            valid_ff <= 1'b0;
            slot0_ff <= '0;
            slot1_ff <= '0;
        end else begin
            count_ff <= nxt_count;
            valid_ff <= nxt_valid;
            slot0_ff <= nxt_slot0;
            slot1_ff <= nxt_slot1;
        end
    end

endmodule

// >>> rtl/sas_params.svh
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

`define SAS_RES_W 12
`define SAS_NUM_CH 8
`define SAS_CH_W 3
`define SAS_SMP_W 8
// system clock and the conversion clock ceiling, in MHz
`define SAS_SYS_CLK_MHZ 20
`define SAS_CONV_CLK_MAX_MHZ 18
// conversion clock as a fractional tick: add STEP, wrap at MOD
`define SAS_TICK_STEP `SAS_CONV_CLK_MAX_MHZ
`define SAS_TICK_MOD `SAS_SYS_CLK_MHZ
`define SAS_ACC_W 5
// least conversion length in conversion clocks, sample included
`define SAS_MIN_CONV_CLKS 18
// successive approximation phase after the aperture
`define SAS_BIT_CLKS 14
`define SAS_MIN_SAMPLE (`SAS_MIN_CONV_CLKS - `SAS_BIT_CLKS)
`define SAS_LOW_RST 12'h000
`define SAS_HIGH_RST 12'hfff

`endif

// >>> rtl/sas_pkg.sv
`include "sas_params.svh"

package sas_pkg;

    typedef logic [`SAS_RES_W-1:0] sas_res_t;
    typedef logic [`SAS_CH_W-1:0] sas_ch_t;

    typedef enum logic [1:0] {
        SAS_IDLE,
        SAS_SAMPLE,
        SAS_CONVERT,
        SAS_HOLD
    } sas_state_e;

    typedef struct packed {
        sas_ch_t chan;
        sas_res_t data;
        logic outOfRange;
    } sas_word_s;

    typedef struct packed {
        sas_res_t low;
        sas_res_t high;
    } sas_limits_s;

endpackage

// >>> rtl/sas_sequencer.sv
// Overview of operation
// - results are 12 bits wide and the sequencer sustains one million samples per second in total.
// - the conversion clock stays at or below 18 MHz and a conversion takes at least 18 of its clocks.
// - the sample aperture length is programmable so slow drivers get more settling time.
// - the sequencer selects among eight fixed analog inputs.
// - a scan steps through enabled channels with no idle clocks between them while the two-word result buffer has room.
// - channels are switched either by the state machine or directly by firmware.
// - each channel has its own result buffer so software may read rarely.
// - each channel has its own sample time used whenever it is converted.
// - a low and a high limit are held and a result outside them raises the out-of-range interrupt.
// - the range check acts on each result as it is produced, not at scan end.
// - the converter and sequencer stop in deep sleep, where the fast clock is gone.
`include "sas_params.svh"

module sas_sequencer
    import sas_pkg::*;
#(
    parameter int NUM_CH = `SAS_NUM_CH,
    parameter int SMP_W = `SAS_SMP_W
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic deepSleep,
    input wire logic fwMode,
    input wire sas_ch_t fwChan,
    input wire logic fwStart,
    input wire logic scanStart,
    input wire logic scanContinuous,
    input wire logic [NUM_CH-1:0] chanEnable,
    input wire logic [NUM_CH-1:0][SMP_W-1:0] sampleTime,
    input wire sas_limits_s limits,
    input wire logic scanDoneClr,
    input wire logic rangeClr,
    input wire sas_res_t sarResult,
    output logic sarPowered,
    output logic sarConvTick,
    output logic sarSample,
    output logic sarConvert,
    output sas_ch_t sarChan,
    output logic busy,
    output logic [NUM_CH-1:0][`SAS_RES_W-1:0] results,
    output logic [NUM_CH-1:0] resultFresh,
    output logic scanDone,
    output logic rangeIrq,
    output sas_ch_t rangeChan,
    output logic resValid,
    input wire logic resReady,
    output sas_word_s resWord
);

    // search upward from start for an enabled channel: {found, index}
    function automatic logic [`SAS_CH_W:0] findFrom(
        input logic [`SAS_CH_W:0] start,
        input logic [NUM_CH-1:0] mask
    );
        logic [`SAS_CH_W:0] hit;
        hit = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (mask[i] && (i >= int'(start))) begin
                hit = {1'b1, i[`SAS_CH_W-1:0]};
            end
        end
        return hit;
    endfunction

    function automatic logic outside(
        input sas_res_t value,
        input sas_limits_s lim
    );
        return (value < lim.low) || (value > lim.high);
    endfunction

    // deep sleep arrives from the power controller, another domain
    logic sleepMeta_ff;
    logic sleepSync_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sleepMeta_ff <= 1'b0;
            sleepSync_ff <= 1'b0;
        end else begin
            sleepMeta_ff <= deepSleep;
            sleepSync_ff <= sleepMeta_ff;
        end
    end

    logic running;
    assign running = enable && !sleepSync_ff;

    // fractional divider: 18 ticks in every 20 clocks, never above 18 MHz
    logic [`SAS_ACC_W-1:0] acc_ff;
    logic [`SAS_ACC_W-1:0] nxt_acc;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        logic [`SAS_ACC_W:0] sum;
        sum = {1'b0, acc_ff} + (`SAS_ACC_W+1)'(`SAS_TICK_STEP);
        nxt_acc = acc_ff;
        nxt_tick = 1'b0;
        if (running) begin
            if (sum >= (`SAS_ACC_W+1)'(`SAS_TICK_MOD)) begin
                nxt_acc = `SAS_ACC_W'(sum - (`SAS_ACC_W+1)'(`SAS_TICK_MOD));
                nxt_tick = 1'b1;
            end else begin
                nxt_acc = sum[`SAS_ACC_W-1:0];
            end
        end else begin
            nxt_acc = '0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            tick_ff <= nxt_tick;
        end
    end

    sas_state_e state_ff;
    sas_state_e nxt_state;
    sas_ch_t chan_ff;
    sas_ch_t nxt_chan;
    logic [SMP_W-1:0] cnt_ff;
    logic [SMP_W-1:0] nxt_cnt;
    logic scanning_ff;
    logic nxt_scanning;
    sas_word_s hold_ff;
    sas_word_s nxt_hold;
    logic [NUM_CH-1:0][`SAS_RES_W-1:0] res_ff;
    logic [NUM_CH-1:0][`SAS_RES_W-1:0] nxt_res;
    logic [NUM_CH-1:0] fresh_ff;
    logic [NUM_CH-1:0] nxt_fresh;
    logic done_ff;
    logic nxt_done;
    logic range_ff;
    logic nxt_range;
    sas_ch_t rangeChan_ff;
    sas_ch_t nxt_rangeChan;

    logic bufValid;
    logic bufReady;
    sas_word_s bufWord;

    logic [`SAS_CH_W:0] first;
    logic [`SAS_CH_W:0] after;
    sas_word_s fresh;
    logic convEnd;

    // the aperture never drops below what keeps 18 clocks in a conversion
    function automatic logic [SMP_W-1:0] aperture(input sas_ch_t ch);
        logic [SMP_W-1:0] t;
        t = sampleTime[ch];
        if (t < SMP_W'(`SAS_MIN_SAMPLE)) begin
            t = SMP_W'(`SAS_MIN_SAMPLE);
        end
        return t - SMP_W'(1);
    endfunction

    always_comb begin
        first = findFrom('0, chanEnable);
        after = findFrom({1'b0, chan_ff} + (`SAS_CH_W+1)'(1), chanEnable);
        convEnd = (state_ff == SAS_CONVERT) && tick_ff
            && (cnt_ff == '0);
        fresh.chan = chan_ff;
        fresh.data = sarResult;
        fresh.outOfRange = outside(sarResult, limits);
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_chan = chan_ff;
        nxt_cnt = cnt_ff;
        nxt_scanning = scanning_ff;
        nxt_hold = hold_ff;
        nxt_res = res_ff;
        nxt_fresh = fresh_ff;
        bufValid = 1'b0;
        bufWord = fresh;
        nxt_done = done_ff && !scanDoneClr;
        nxt_range = range_ff && !rangeClr;
        nxt_rangeChan = rangeChan_ff;
        case (state_ff)
            SAS_IDLE: begin
                if (fwMode && fwStart) begin
                    nxt_chan = fwChan;
                    nxt_scanning = 1'b0;
                    nxt_cnt = aperture(fwChan);
                    nxt_state = SAS_SAMPLE;
                end else if (!fwMode && (scanStart || scanContinuous)
                        && first[`SAS_CH_W]) begin
                    nxt_chan = first[`SAS_CH_W-1:0];
                    nxt_scanning = 1'b1;
                    nxt_cnt = aperture(first[`SAS_CH_W-1:0]);
                    nxt_state = SAS_SAMPLE;
                end
            end
            SAS_SAMPLE: begin
                if (tick_ff) begin
                    if (cnt_ff == '0) begin
                        nxt_cnt = SMP_W'(`SAS_BIT_CLKS - 1);
                        nxt_state = SAS_CONVERT;
                    end else begin
                        nxt_cnt = cnt_ff - SMP_W'(1);
                    end
                end
            end
            SAS_CONVERT: begin
                if (tick_ff && cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - SMP_W'(1);
                end
            end
            SAS_HOLD: begin
                bufValid = 1'b1;
                bufWord = hold_ff;
            end
            default: begin
                nxt_state = SAS_IDLE;
            end
        endcase
        if (convEnd) begin
            nxt_res[chan_ff] = sarResult;
            nxt_fresh[chan_ff] = 1'b1;
            nxt_hold = fresh;
            bufValid = 1'b1;
            if (fresh.outOfRange) begin
                nxt_range = 1'b1;
                nxt_rangeChan = chan_ff;
            end
        end
        // leave the converter only once the word is safely buffered or the sequencer stops running
        if ((convEnd || state_ff == SAS_HOLD) && !bufReady) begin
            nxt_state = SAS_HOLD;
        end else if (convEnd || state_ff == SAS_HOLD) begin
            if (scanning_ff && after[`SAS_CH_W] && !fwMode) begin
                // next channel samples on the very next tick
                nxt_chan = after[`SAS_CH_W-1:0];
                nxt_cnt = aperture(after[`SAS_CH_W-1:0]);
                nxt_state = SAS_SAMPLE;
            end else if (scanning_ff) begin
                nxt_done = 1'b1;
                if (scanContinuous && first[`SAS_CH_W] && !fwMode) begin
                    nxt_chan = first[`SAS_CH_W-1:0];
                    nxt_cnt = aperture(first[`SAS_CH_W-1:0]);
                    nxt_state = SAS_SAMPLE;
                end else begin
                    nxt_scanning = 1'b0;
                    nxt_state = SAS_IDLE;
                end
            end else begin
                nxt_state = SAS_IDLE;
            end
        end
        // a sleeping converter has no clock; abandon the conversion
        if (!running) begin
            nxt_state = SAS_IDLE;
            nxt_scanning = 1'b0;
            bufValid = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= SAS_IDLE;
            chan_ff <= '0;
            cnt_ff <= '0;
            scanning_ff <= 1'b0;
            hold_ff <= '0;
            res_ff <= '0;
            fresh_ff <= '0;
            done_ff <= 1'b0;
            range_ff <= 1'b0;
            rangeChan_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            chan_ff <= nxt_chan;
            cnt_ff <= nxt_cnt;
            scanning_ff <= nxt_scanning;
            hold_ff <= nxt_hold;
            res_ff <= nxt_res;
            fresh_ff <= nxt_fresh;
            done_ff <= nxt_done;
            range_ff <= nxt_range;
            rangeChan_ff <= nxt_rangeChan;
        end
    end

    // front-end strobes registered so the core sees clean levels
    logic powered_ff;
    logic sample_ff;
    logic convert_ff;
    logic convTick_ff;
    sas_ch_t sarChan_ff;
    logic busy_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            powered_ff <= 1'b0;
            sample_ff <= 1'b0;
            convert_ff <= 1'b0;
            convTick_ff <= 1'b0;
            sarChan_ff <= '0;
            busy_ff <= 1'b0;
        end else begin
            powered_ff <= running;
            sample_ff <= (nxt_state == SAS_SAMPLE);
            convert_ff <= (nxt_state == SAS_CONVERT);
            convTick_ff <= nxt_tick;
            sarChan_ff <= nxt_chan;
            busy_ff <= (nxt_state != SAS_IDLE);
        end
    end

    sas_buf2 #(
        .W($bits(sas_word_s))
    ) u_buf (
        .clock(clock),
        .arst_n(arst_n),
        .inValid(bufValid),
        .inReady(bufReady),
        .inData(bufWord),
        .outValid(resValid),
        .outReady(resReady),
        .outData(resWord)
    );

    assign sarPowered = powered_ff;
    assign sarConvTick = convTick_ff;
    assign sarSample = sample_ff;
    assign sarConvert = convert_ff;
    assign sarChan = sarChan_ff;
    assign busy = busy_ff;
    assign results = res_ff;
    assign resultFresh = fresh_ff;
    assign scanDone = done_ff;
    assign rangeIrq = range_ff;
    assign rangeChan = rangeChan_ff;

endmodule

// >>> verif/sas_sar_model.sv
module sas_sar_model
    import sas_pkg::*;
(
    input wire logic clock,
    input wire logic sarConvert,
    input wire sas_ch_t sarChan,
    output sas_res_t sarResult = 12'h5a5
);
    timeunit 1ns;
    timeprecision 1ns;

    // channel in the top bits so each word shows where it came from
    always_ff @(posedge clock) begin
        if (sarConvert) begin
            sarResult <= {sarChan, 9'h1a5};
        end else begin
            // no result outside the bit phase: lines keep moving
            sarResult <= ~sarResult;
        end
    end
endmodule

// >>> verif/sas_sequencer_chk.sv
`include "sas_params.svh"

module sas_sequencer_chk
    import sas_pkg::*;
#(
    parameter int NUM_CH = `SAS_NUM_CH,
    parameter int SMP_W = `SAS_SMP_W
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire sas_limits_s limits,
    input wire logic sarConvTick,
    input wire logic sarSample,
    input wire logic sarConvert,
    input wire sas_ch_t sarChan,
    input wire logic busy,
    input wire logic [NUM_CH-1:0][`SAS_RES_W-1:0] results,
    input wire logic rangeIrq,
    input wire sas_ch_t rangeChan,
    input wire logic resValid,
    input wire sas_word_s resWord
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // ticks seen in a row; 18 in every 20 allows nine at the most
    logic [3:0] tickRun_ff;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tickRun_ff <= 4'h0;
        end else if (!sarConvTick) begin
            tickRun_ff <= 4'h0;
        end else if (tickRun_ff != 4'hf) begin
            tickRun_ff <= tickRun_ff + 4'h1;
        end
    end

    sequence s_aperture;
        sarSample [*4];
    endsequence
    sequence s_bits;
        sarConvert [*8];
    endsequence

    property p_phases;
        !(sarSample && sarConvert);
    endproperty
    a_phases: assert property (p_phases)
        else $error("sample and bit phases overlap");
    // 18 of 20 ticks leaves a gap in every ten cycles
    property p_tickRate;
        sarConvTick |-> tickRun_ff < 4'h9;
    endproperty
    a_tickRate: assert property (p_tickRate)
        else $error("conversion clock too fast");
    property p_aperture;
        $rose(sarSample) |-> s_aperture;
    endproperty
    a_aperture: assert property (p_aperture)
        else $error("aperture shorter than minimum");
    property p_handoff;
        $fell(sarSample) && busy |-> s_bits;
    endproperty
    a_handoff: assert property (p_handoff)
        else $error("bit phase missing or short");
    property p_convCause;
        $rose(sarConvert) |-> $past(sarSample);
    endproperty
    a_convCause: assert property (p_convCause)
        else $error("bit phase without aperture");
    property p_chanHeld;
        sarConvert |-> $stable(sarChan);
    endproperty
    a_chanHeld: assert property (p_chanHeld)
        else $error("mux moved during conversion");
    property p_window;
        resValid |-> resWord.outOfRange == (resWord.data < limits.low
            || resWord.data > limits.high);
    endproperty
    a_window: assert property (p_window)
        else $error("range flag wrong");
    property p_early;
        $rose(resValid) && resWord.outOfRange |->
            rangeIrq && rangeChan == resWord.chan;
    endproperty
    a_early: assert property (p_early)
        else $error("range interrupt late or wrong channel");
    property p_bufKeep;
        $rose(resValid) |-> results[resWord.chan] == resWord.data;
    endproperty
    a_bufKeep: assert property (p_bufKeep)
        else $error("channel buffer not updated");
endmodule

bind sas_sequencer sas_sequencer_chk #(
    .NUM_CH(NUM_CH), .SMP_W(SMP_W)
) u_chk (
    .clock(clock), .arst_n(arst_n), .limits(limits),
    .sarConvTick(sarConvTick), .sarSample(sarSample),
    .sarConvert(sarConvert), .sarChan(sarChan), .busy(busy),
    .results(results), .rangeIrq(rangeIrq), .rangeChan(rangeChan),
    .resValid(resValid), .resWord(resWord)
);

// >>> verif/tb_top.sv
`include "sas_params.svh"

module tb_top
    import sas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        sas_ch_t chan;
        logic [7:0] ap;
        logic [7:0] expAp;
        logic expOut;
    } sas_row_s;

    // below the floor of 4 the aperture is raised to 4
    localparam sas_row_s ROWS [8] = '{'{3'h0, 8'h00, 8'h04, 1'b1},
        '{3'h1, 8'h03, 8'h04, 1'b0}, '{3'h2, 8'h04, 8'h04, 1'b0},
        '{3'h3, 8'h05, 8'h05, 1'b0}, '{3'h4, 8'h10, 8'h10, 1'b0},
        '{3'h5, 8'hff, 8'hff, 1'b0}, '{3'h6, 8'h07, 8'h07, 1'b1},
        '{3'h7, 8'h04, 8'h04, 1'b1}};

    logic clock, arst_n, enable, deepSleep, fwMode, fwStart, scanStart;
    logic scanContinuous, scanDoneClr, rangeClr, resReady;
    logic sarPowered, sarConvTick, sarSample, sarConvert, busy;
    logic scanDone, rangeIrq, resValid;
    sas_ch_t fwChan, sarChan, rangeChan;
    logic [7:0] chanEnable, resultFresh;
    logic [7:0][7:0] sampleTime;
    logic [7:0][11:0] results;
    sas_limits_s limits;
    sas_res_t sarResult;
    sas_word_s resWord;
    logic [1:0] watch;
    int failures, compares, apTicks, gaps;

    assign watch = {busy, resValid};

    sas_sequencer u_dut (.clock(clock), .arst_n(arst_n), .enable(enable),
        .deepSleep(deepSleep), .fwMode(fwMode), .fwChan(fwChan),
        .fwStart(fwStart), .scanStart(scanStart),
        .scanContinuous(scanContinuous), .chanEnable(chanEnable),
        .sampleTime(sampleTime), .limits(limits),
        .scanDoneClr(scanDoneClr), .rangeClr(rangeClr),
        .sarResult(sarResult), .sarPowered(sarPowered),
        .sarConvTick(sarConvTick), .sarSample(sarSample),
        .sarConvert(sarConvert), .sarChan(sarChan), .busy(busy),
        .results(results), .resultFresh(resultFresh),
        .scanDone(scanDone), .rangeIrq(rangeIrq), .rangeChan(rangeChan),
        .resValid(resValid), .resReady(resReady), .resWord(resWord));

    sas_sar_model u_sar (.clock(clock), .sarConvert(sarConvert),
        .sarChan(sarChan), .sarResult(sarResult));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock) begin
        if (sarSample && sarConvTick) begin
            apTicks++;
        end
        if (busy && !sarSample && !sarConvert) begin
            gaps++;
        end
    end

    task automatic close_out();
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_bit(string what, logic exp, logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s exp %b got %b", what, exp, got);
        end
    endtask

    task automatic chk_val(string what, sas_res_t exp, sas_res_t got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic wait_for(int idx, logic lvl, int lim);
        int n;
        n = 0;
        while (watch[idx] !== lvl) begin
            @(negedge clock);
            n++;
            if (n > lim) begin
                failures++;
                close_out();
            end
        end
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clock);
        sig = 1'b0;
    endtask

    // a stall longer than two words forces the sequencer to wait
    task automatic run_scan(logic [7:0] mask, int stall);
        int n;
        gaps = 0;
        chanEnable = mask;
        resReady = (stall == 0);
        pulse(scanStart);
        repeat (stall) @(negedge clock);
        if (stall > 0) begin
            chk_bit("heldValid", 1'b1, resValid);
            chk_bit("heldBusy", 1'b1, busy);
        end
        resReady = 1'b1;
        for (n = 0; n < 8; n++) begin
            if (mask[n]) begin
                wait_for(0, 1'b1, 600);
                chk_val("scanChan", 12'(n), 12'(resWord.chan));
                chk_val("scanData", {3'(n), 9'h1a5}, resWord.data);
                @(negedge clock);
            end
        end
        wait_for(1, 1'b0, 60);
        chk_bit("scanDone", 1'b1, scanDone);
        if (stall == 0) begin
            chk_val("gaps", 12'h000, 12'(gaps));
        end
        pulse(scanDoneClr);
        chk_bit("doneClr", 1'b0, scanDone);
    endtask

    initial begin
        {arst_n, deepSleep, fwStart, scanStart, scanContinuous} = '0;
        {scanDoneClr, rangeClr, fwChan, chanEnable} = '0;
        {enable, fwMode, resReady} = 3'h7;
        sampleTime = {8{8'h04}};
        limits = '{low: 12'h300, high: 12'hc00};
        failures = 0;
        compares = 0;
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        chk_bit("rstDone", 1'b0, scanDone);
        chk_bit("rstIrq", 1'b0, rangeIrq);
        chk_val("rstFresh", 12'h000, 12'(resultFresh));
        repeat (4) @(negedge clock);
        foreach (ROWS[i]) begin
            sampleTime[ROWS[i].chan] = ROWS[i].ap;
            fwChan = ROWS[i].chan;
            apTicks = 0;
            pulse(fwStart);
            wait_for(0, 1'b1, 600);
            chk_val("ap", 12'(ROWS[i].expAp), 12'(apTicks));
            chk_val("chan", 12'(ROWS[i].chan), 12'(resWord.chan));
            chk_val("data", {ROWS[i].chan, 9'h1a5}, resWord.data);
            chk_bit("out", ROWS[i].expOut, resWord.outOfRange);
            chk_val("buf", {ROWS[i].chan, 9'h1a5},
                results[ROWS[i].chan]);
            chk_bit("fresh", 1'b1, resultFresh[ROWS[i].chan]);
            wait_for(1, 1'b0, 40);
        end
        chk_bit("irq", 1'b1, rangeIrq);
        chk_val("irqChan", 12'h007, 12'(rangeChan));
        pulse(rangeClr);
        chk_bit("irqClr", 1'b0, rangeIrq);
        deepSleep = 1'b1;
        repeat (4) @(negedge clock);
        chk_bit("sleepPwr", 1'b0, sarPowered);
        pulse(fwStart);
        repeat (3) @(negedge clock);
        chk_bit("sleepBusy", 1'b0, busy);
        deepSleep = 1'b0;
        repeat (5) @(negedge clock);
        chk_bit("wakePwr", 1'b1, sarPowered);
        fwMode = 1'b0;
        run_scan(8'hff, 0);
        run_scan(8'h1c, 150);
        // continuous scan wraps from the last channel to the first
        chanEnable = 8'h81;
        gaps = 0;
        scanContinuous = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wait_for(0, 1'b1, 600);
            chk_val("contChan", k[0] ? 12'h007 : 12'h000,
                12'(resWord.chan));
            @(negedge clock);
        end
        chk_bit("contDone", 1'b1, scanDone);
        scanContinuous = 1'b0;
        wait_for(1, 1'b0, 100);
        chk_val("contGaps", 12'h000, 12'(gaps));
        close_out();
    end
endmodule
